// ### shared/rhc_pkg.sv
package rhc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int HDR_BYTES = 4;
  localparam int IRQ_W = 3;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHK_B1 = 8'h3C;
  localparam logic [7:0] IDX_PKLEN = 8'h3E;
  localparam logic [7:0] IDX_CHK_B3 = 8'h3F;
  localparam logic [7:0] IDX_CHK_B2 = 8'h40;
  localparam logic [7:0] IDX_CHK_B0 = 8'h42;
  localparam logic [7:0] IDX_MSK_B3 = 8'h43;
  localparam logic [7:0] IDX_MSK_B2 = 8'h44;
  localparam logic [7:0] IDX_MSK_B1 = 8'h45;
  localparam logic [7:0] IDX_MSK_B0 = 8'h46;
  localparam logic [7:0] IDX_RXH_B3 = 8'h47;
  localparam logic [7:0] IDX_RXH_B2 = 8'h48;
  localparam logic [7:0] IDX_RXH_B1 = 8'h49;
  localparam logic [7:0] IDX_RXH_B0 = 8'h4A;
  localparam logic [7:0] IDX_RXLEN = 8'h4B;
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h61;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
  localparam logic [7:0] IDX_STATE = 8'h63;
  // Control register fields
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_CHK_EN_BIT = 1;
  localparam int CTRL_FIX_BIT = 3;
  localparam int CTRL_HLEN_LSB = 4;
  localparam int HLEN_W = 3;
  localparam logic [2:0] HDR_SEL_MAX = 3'h4;
  // Interrupt status bits
  localparam int IRQ_HDR_OK = 0;
  localparam int IRQ_HDR_ERR = 1;
  localparam int IRQ_PKT_DONE = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_RXLEN = 8'hFF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR = 5'b00010,
    ST_CHK = 5'b00100,
    ST_LEN = 5'b01000,
    ST_DATA = 5'b10000
  } rhc_state_type;
endpackage : rhc_pkg

// ### shared/rhc_if.sv
`timescale 1ns/100ps
interface rhc_bus_if;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rsnap;
  logic [7:0] rdata;
  modport slave(output idx, wdata, wr_stb, rd_stb, rsnap, input rdata);
  modport regs(input idx, wdata, wr_stb, rd_stb, rsnap, output rdata);
endinterface : rhc_bus_if

interface rhc_cmp_if;
  logic [31:0] rx_hdr;
  logic [31:0] chk_hdr;
  logic [31:0] bit_en;
  logic [3:0] byte_used;
  logic mismatch;
  modport req(output rx_hdr, chk_hdr, bit_en, byte_used, input mismatch);
  modport cmp(input rx_hdr, chk_hdr, bit_en, byte_used, output mismatch);
endinterface : rhc_cmp_if

// ### design/rhc_hdr_cmp.sv
`timescale 1ns/100ps
module rhc_hdr_cmp
  import rhc_pkg::*;
(
  // Compare request
  rhc_cmp_if.cmp c
);
  logic [HDR_BYTES-1:0] byte_err;

  genvar i;
  generate
    for (i = 0; i < HDR_BYTES; i++) begin : g_byte
      // Masked bits and bytes not received never count
      assign byte_err[i] = c.byte_used[i] &
        (|((c.rx_hdr[8*i+:8] ^ c.chk_hdr[8*i+:8]) & c.bit_en[8*i+:8]));
    end
  endgenerate

  assign c.mismatch = |byte_err;
endmodule : rhc_hdr_cmp

// ### design/rhc_avmm_slave.sv
`timescale 1ns/100ps
module rhc_avmm_slave
  import rhc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic avs_waitrequest,
  output logic [DATA_W-1:0] avs_readdata,
  // Register side
  rhc_bus_if.slave bus
);
  logic wait_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic req;
  logic acc;

  assign req = avs_read | avs_write;
  // Accepted in the one cycle that waitrequest is low
  assign acc = req & ~wait_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end

  // Read data captured one cycle ahead so it stands when wait drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RST_WORD;
    end else if (avs_read & wait_reg) begin
      rdata_reg <= {24'h00_0000, bus.rdata};
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign bus.idx = avs_address[ADDR_W-1:2];
  assign bus.wdata = avs_writedata[7:0];
  assign bus.wr_stb = acc & avs_write & avs_byteenable[0];
  assign bus.rd_stb = acc & avs_read;
  assign bus.rsnap = rdata_reg[7:0];
endmodule : rhc_avmm_slave

// ### design/rhc_top.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module rhc_top
  import rhc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Avalon-MM register port
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic AVS_WAITREQUEST,
  output logic [DATA_W-1:0] AVS_READDATA,
  // Demodulated byte stream
  input wire logic RX_SYNC_FOUND,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_BYTE_VALID,
  // Packet output
  output logic [7:0] RX_DATA,
  output logic RX_DATA_VALID,
  output logic RX_PKT_DONE,
  output logic RX_PKT_REJECT,
  // Interrupt
  output logic IRQ
);
  rhc_bus_if bus ();
  rhc_cmp_if cmp ();

  logic [31:0] chk_hdr_reg;
  logic [31:0] hdr_en_reg;
  logic [31:0] rx_hdr_reg;
  logic [7:0] pklen_reg;
  logic [7:0] rxlen_reg;
  logic [7:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  rhc_state_type state_reg;
  logic [2:0] hdr_cnt_reg;
  logic [1:0] hdr_pos_reg;
  logic [3:0] used_reg;
  logic [7:0] data_cnt_reg;
  logic chk_en_lat_reg;
  logic fix_lat_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;
  logic done_reg;
  logic reject_reg;

  logic [2:0] hlen_sel;
  logic [2:0] hsel;
  logic start;
  logic byte_in;
  logic ev_ok;
  logic ev_err;
  logic ev_done;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr_mask;

  rhc_avmm_slave u_bus (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .avs_address(AVS_ADDRESS),
    .avs_read(AVS_READ),
    .avs_write(AVS_WRITE),
    .avs_writedata(AVS_WRITEDATA),
    .avs_byteenable(AVS_BYTEENABLE),
    .avs_waitrequest(AVS_WAITREQUEST),
    .avs_readdata(AVS_READDATA),
    .bus(bus)
  );

  rhc_hdr_cmp u_cmp (
    .c(cmp)
  );

  assign cmp.rx_hdr = rx_hdr_reg;
  assign cmp.chk_hdr = chk_hdr_reg;
  assign cmp.bit_en = hdr_en_reg;
  assign cmp.byte_used = used_reg;

  // Codes above four are clamped to the full header
  assign hlen_sel = ctrl_reg[CTRL_HLEN_LSB+:HLEN_W];
  assign hsel = (hlen_sel > HDR_SEL_MAX) ? HDR_SEL_MAX : hlen_sel;
  // A sync inside a packet is ignored; no restart mid-frame
  assign start = (state_reg == ST_IDLE) & RX_SYNC_FOUND & ctrl_reg[CTRL_RX_EN_BIT];
  assign byte_in = RX_BYTE_VALID;

  assign ev_err = (state_reg == ST_CHK) & chk_en_lat_reg & cmp.mismatch;
  assign ev_ok = (state_reg == ST_CHK) & chk_en_lat_reg & ~cmp.mismatch & (|used_reg);

  always_comb begin
    ev_done = 1'b0;
    case (state_reg)
      ST_CHK: begin
        ev_done = ~ev_err & fix_lat_reg & (data_cnt_reg == 8'h00);
      end
      ST_LEN: begin
        ev_done = byte_in & (RX_BYTE == 8'h00);
      end
      ST_DATA: begin
        ev_done = byte_in & (data_cnt_reg == 8'h01);
      end
      default: begin
        ev_done = 1'b0;
      end
    endcase
  end

  // Packet sequencing
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      hdr_cnt_reg <= 3'h0;
      hdr_pos_reg <= 2'h3;
      used_reg <= 4'h0;
      data_cnt_reg <= RST_BYTE;
      chk_en_lat_reg <= 1'b0;
      fix_lat_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // Settings are frozen for the whole packet
            chk_en_lat_reg <= ctrl_reg[CTRL_CHK_EN_BIT];
            fix_lat_reg <= ctrl_reg[CTRL_FIX_BIT];
            data_cnt_reg <= pklen_reg;
            hdr_cnt_reg <= hsel;
            hdr_pos_reg <= 2'h3;
            used_reg <= 4'h0;
            state_reg <= (hsel == 3'h0) ? ST_CHK : ST_HDR;
          end
        end
        ST_HDR: begin
          if (byte_in) begin
            used_reg[hdr_pos_reg] <= 1'b1;
            hdr_pos_reg <= hdr_pos_reg - 2'h1;
            hdr_cnt_reg <= hdr_cnt_reg - 3'h1;
            if (hdr_cnt_reg == 3'h1) begin
              state_reg <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          if (ev_err) begin
            state_reg <= ST_IDLE;
          end else if (!fix_lat_reg) begin
            state_reg <= ST_LEN;
          end else if (data_cnt_reg == 8'h00) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_DATA;
          end
        end
        ST_LEN: begin
          if (byte_in) begin
            data_cnt_reg <= RX_BYTE;
            state_reg <= (RX_BYTE == 8'h00) ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_in) begin
            data_cnt_reg <= data_cnt_reg - 8'h01;
            if (data_cnt_reg == 8'h01) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Received header capture
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_hdr_reg <= RST_WORD;
    end else if (start) begin
      rx_hdr_reg <= RST_WORD;
    end else if ((state_reg == ST_HDR) & byte_in) begin
      rx_hdr_reg[8*hdr_pos_reg+:8] <= RX_BYTE;
    end
  end

  // Received length byte; fixed-length packets leave it untouched
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rxlen_reg <= RST_RXLEN;
    end else if ((state_reg == ST_LEN) & byte_in) begin
      rxlen_reg <= RX_BYTE;
    end
  end

  // Data and packet strobes
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_data_reg <= RST_BYTE;
      rx_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      rx_valid_reg <= (state_reg == ST_DATA) & byte_in;
      if ((state_reg == ST_DATA) & byte_in) begin
        rx_data_reg <= RX_BYTE;
      end
      done_reg <= ev_done;
      reject_reg <= ev_err;
    end
  end

  // Software registers
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      chk_hdr_reg <= RST_WORD;
      hdr_en_reg <= RST_WORD;
      pklen_reg <= RST_BYTE;
      ctrl_reg <= RST_BYTE;
      irq_mask_reg <= '0;
    end else if (bus.wr_stb) begin
      case (bus.idx)
        IDX_CHK_B3: chk_hdr_reg[31:24] <= bus.wdata;
        IDX_CHK_B2: chk_hdr_reg[23:16] <= bus.wdata;
        IDX_CHK_B1: chk_hdr_reg[15:8] <= bus.wdata;
        IDX_CHK_B0: chk_hdr_reg[7:0] <= bus.wdata;
        IDX_MSK_B3: hdr_en_reg[31:24] <= bus.wdata;
        IDX_MSK_B2: hdr_en_reg[23:16] <= bus.wdata;
        IDX_MSK_B1: hdr_en_reg[15:8] <= bus.wdata;
        IDX_MSK_B0: hdr_en_reg[7:0] <= bus.wdata;
        IDX_PKLEN: pklen_reg <= bus.wdata;
        IDX_CTRL: ctrl_reg <= bus.wdata;
        IDX_IRQ_MASK: irq_mask_reg <= bus.wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    case (bus.idx)
      IDX_CHK_B3: bus.rdata = chk_hdr_reg[31:24];
      IDX_CHK_B2: bus.rdata = chk_hdr_reg[23:16];
      IDX_CHK_B1: bus.rdata = chk_hdr_reg[15:8];
      IDX_CHK_B0: bus.rdata = chk_hdr_reg[7:0];
      IDX_MSK_B3: bus.rdata = hdr_en_reg[31:24];
      IDX_MSK_B2: bus.rdata = hdr_en_reg[23:16];
      IDX_MSK_B1: bus.rdata = hdr_en_reg[15:8];
      IDX_MSK_B0: bus.rdata = hdr_en_reg[7:0];
      IDX_RXH_B3: bus.rdata = rx_hdr_reg[31:24];
      IDX_RXH_B2: bus.rdata = rx_hdr_reg[23:16];
      IDX_RXH_B1: bus.rdata = rx_hdr_reg[15:8];
      IDX_RXH_B0: bus.rdata = rx_hdr_reg[7:0];
      IDX_PKLEN: bus.rdata = pklen_reg;
      IDX_RXLEN: bus.rdata = rxlen_reg;
      IDX_CTRL: bus.rdata = ctrl_reg;
      IDX_IRQ_STAT: bus.rdata = {5'h00, irq_stat_reg};
      IDX_IRQ_MASK: bus.rdata = {5'h00, irq_mask_reg};
      IDX_STATE: bus.rdata = {3'h0, state_reg};
      default: bus.rdata = 8'h00;
    endcase
  end

  assign events[IRQ_HDR_OK] = ev_ok;
  assign events[IRQ_HDR_ERR] = ev_err;
  assign events[IRQ_PKT_DONE] = ev_done;
  // Only bits returned by the read are cleared, so a late event survives
  assign clr_mask = (bus.rd_stb & (bus.idx == IDX_IRQ_STAT)) ?
    bus.rsnap[IRQ_W-1:0] : '0;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign RX_DATA = rx_data_reg;
  assign RX_DATA_VALID = rx_valid_reg;
  assign RX_PKT_DONE = done_reg;
  assign RX_PKT_REJECT = reject_reg;
  assign IRQ = irq_reg;
endmodule : rhc_top

// ### sim/rhc_props.sv
`timescale 1ns/100ps
module rhc_props
  import rhc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Register port
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [DATA_W-1:0] AVS_READDATA,
  // Byte stream
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_BYTE_VALID,
  // Packet output
  input wire logic [7:0] RX_DATA,
  input wire logic RX_DATA_VALID,
  input wire logic RX_PKT_DONE,
  input wire logic RX_PKT_REJECT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence req_s;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence ans_s;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("request not answered after one wait");
  idle_wait_a: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("waitrequest low without request");
  low_lane_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
    else $error("read data outside the low byte");
  rdata_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  data_cause_a: assert property (RX_DATA_VALID |-> $past(RX_BYTE_VALID)
    && RX_DATA == $past(RX_BYTE))
    else $error("data byte without matching input byte");
  done_pulse_a: assert property (RX_PKT_DONE |=> !RX_PKT_DONE)
    else $error("packet done longer than one cycle");
  reject_pulse_a: assert property (RX_PKT_REJECT |=> !RX_PKT_REJECT && !RX_DATA_VALID)
    else $error("rejected packet still delivers data");
  reject_only_a: assert property (RX_PKT_REJECT |-> !RX_PKT_DONE && !RX_DATA_VALID)
    else $error("rejected packet also completes");
endmodule : rhc_props

bind rhc_top rhc_props u_props (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
  .RX_BYTE(RX_BYTE), .RX_BYTE_VALID(RX_BYTE_VALID), .RX_DATA(RX_DATA),
  .RX_DATA_VALID(RX_DATA_VALID), .RX_PKT_DONE(RX_PKT_DONE), .RX_PKT_REJECT(RX_PKT_REJECT));

// ### sim/rhc_rx_src.sv
`timescale 1ns/100ps
module rhc_rx_src (
  // Clock
  input wire logic clk,
  // Byte stream
  output logic sync_found = 1'b0,
  output logic [7:0] rx_byte = 8'h5A,
  output logic rx_valid = 1'b0
);
  // Spare cycles after sync cover a header length of zero
  task start_pkt();
    sync_found <= 1'b1;
    @(posedge clk);
    sync_found <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : start_pkt
  task put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    // A released line must not keep showing the byte
    rx_byte <= ~b;
    @(posedge clk);
  endtask : put
endmodule : rhc_rx_src

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench
  import rhc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wreq = 1'b0;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic wait_rq, sync, bval, dval, done, rej, irq;
  logic [DATA_W-1:0] rdata;
  logic [7:0] byte_in, dout, v;
  logic [7:0] regs [13] = '{IDX_CHK_B1, IDX_PKLEN, IDX_CHK_B3, IDX_CHK_B2, IDX_CHK_B0,
    IDX_MSK_B3, IDX_MSK_B2, IDX_MSK_B1, IDX_MSK_B0, IDX_RXH_B3, IDX_RXH_B2, IDX_RXH_B1,
    IDX_RXH_B0};
  int errors = 0;
  int samples_checked = 0;
  int nd, ndone, nrej;

  always #12.5 core_clk = ~core_clk;

  rhc_top dut (.CORE_CLK(core_clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wreq), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_WAITREQUEST(wait_rq),
    .AVS_READDATA(rdata), .RX_SYNC_FOUND(sync), .RX_BYTE(byte_in), .RX_BYTE_VALID(bval),
    .RX_DATA(dout), .RX_DATA_VALID(dval), .RX_PKT_DONE(done), .RX_PKT_REJECT(rej),
    .IRQ(irq));
  rhc_rx_src src (.clk(core_clk), .sync_found(sync), .rx_byte(byte_in), .rx_valid(bval));

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task end_sim();
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    rd <= ~w;
    wreq <= w;
    addr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    // Only the watchdog ends a wait that never sees an answer
    do @(posedge core_clk); while (wait_rq !== 1'b0);
    v = rdata[7:0];
    rd <= 1'b0;
    wreq <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task rd_chk(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(v, e);
  endtask : rd_chk

  task irq_chk(input logic [31:0] e);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), e);
  endtask : irq_chk

  task cfg(input logic [31:0] c, input logic [31:0] m);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, IDX_CHK_B3 + 8'(k == 0 ? 0 : (k == 1 ? 1 : (k == 2 ? -3 : 3))), c[31-8*k -: 8]);
      bus(1'b1, IDX_MSK_B3 + 8'(k), m[31-8*k -: 8]);
    end
  endtask : cfg

  task rxh_chk(input logic [31:0] h);
    for (int k = 0; k < 4; k++) rd_chk(IDX_RXH_B3 + 8'(k), h[31-8*k -: 8]);
  endtask : rxh_chk

  task pkt(input logic [7:0] ctrl, input int nh, input logic [31:0] h, input int ndata);
    bus(1'b1, IDX_CTRL, ctrl);
    nd = 0;
    ndone = 0;
    nrej = 0;
    src.start_pkt();
    for (int k = 0; k < nh; k++) src.put(h[31-8*k -: 8]);
    if (!ctrl[CTRL_FIX_BIT]) src.put(ndata[7:0]);
    for (int k = 0; k < ndata; k++) src.put(k[7:0] ^ 8'hA5);
    repeat (4) @(posedge core_clk);
  endtask : pkt

  always @(posedge core_clk) begin
    if (dval === 1'b1) begin
      chk(dout, nd[7:0] ^ 8'hA5);
      nd++;
    end
    if (done === 1'b1) ndone++;
    if (rej === 1'b1) nrej++;
  end

  initial begin
    #500_000;
    errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    foreach (regs[k]) rd_chk(regs[k], 8'h00);
    rd_chk(IDX_RXLEN, 8'hFF);
    rd_chk(IDX_STATE, 8'h01);
    foreach (regs[k]) bus(1'b1, regs[k], regs[k] ^ 8'hC3);
    foreach (regs[k]) rd_chk(regs[k], k < 9 ? regs[k] ^ 8'hC3 : 8'h00);
    rd_chk(8'h10, 8'h00);
    bus(1'b1, IDX_IRQ_MASK, 8'h07);
    cfg(32'h12345678, 32'hFFFFFFFF);
    pkt(8'h43, 4, 32'h12345678, 2);
    chk(nd, 2);
    chk(ndone, 1);
    rxh_chk(32'h12345678);
    rd_chk(IDX_RXLEN, 8'h02);
    irq_chk(1);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    irq_chk(0);
    bus(1'b1, IDX_IRQ_MASK, 8'h07);
    rd_chk(IDX_IRQ_STAT, 8'h05);
    irq_chk(0);
    rd_chk(IDX_IRQ_STAT, 8'h00);
    cfg(32'h12345678, 32'hFF000000);
    pkt(8'h43, 4, 32'h12999999, 1);
    chk(nrej, 0);
    rd_chk(IDX_IRQ_STAT, 8'h05);
    cfg(32'h12345678, 32'h00000100);
    pkt(8'h43, 4, 32'h12345778, 0);
    chk(nrej + ndone * 2, 1);
    rd_chk(IDX_IRQ_STAT, 8'h02);
    pkt(8'h41, 4, 32'h12345778, 0);
    chk(nrej + ndone * 2, 2);
    rd_chk(IDX_IRQ_STAT, 8'h04);
    bus(1'b1, IDX_PKLEN, 8'hFF);
    pkt(8'h19, 1, 32'hAB000000, 255);
    chk(nd + ndone * 1000, 1255);
    bus(1'b1, IDX_PKLEN, 8'h00);
    pkt(8'h19, 1, 32'hAB000000, 0);
    chk(nd + ndone * 1000, 1000);
    for (int c = 0; c <= 4; c++) begin
      pkt({1'b0, 3'(c), 4'h9}, c, 32'hC1C2C3C4, 0);
      rxh_chk(32'hC1C2C3C4 & ~(32'hFFFFFFFF >> (8 * c)));
    end
    // Header length codes above four take the full header
    pkt(8'h79, 4, 32'hD1D2D3D4, 0);
    rxh_chk(32'hD1D2D3D4);
    be <= 4'hE;
    bus(1'b1, IDX_PKLEN, 8'h77);
    be <= 4'hF;
    rd_chk(IDX_PKLEN, 8'h00);
    end_sim();
  end
endmodule : testbench
